// ---- verilog/cef_top.sv ----
// Emergency messages, speed inputs, filter selection and heartbeat
//
// What this block does
// R1 - Speed inputs feed the computation only while Kalman filter is active.
// R2 - Speed values take effect only when mapped into a receive PDO.
// R3 - Speed array sub-index zero is constant and reports three axes.
// R4 - Axes X, Y, Z are signed 16-bit, writable and receive-PDO mappable.
// R5 - Filter selection changes are accepted only in pre-operational state.
// R6 - New filter selection becomes active only after node reinitialisation.
// R7 - Filter code 0 is complementary (reset default), 1 is Kalman.
// R8 - Manufacturer field of each emergency message is one byte.
// R9 - Byte 2 of every emergency message holds the error register.
// R10 - Return to error-free sends code 0000h with bitfield zero.
// R11 - Entering error passive sends code 8120h with bitfield bit 5.
// R12 - Recovery from bus-off sends code 8140h with bitfield bit 6.
// R13 - Device faults send FF00h with cause in bitfield bit 1, 3 or 4.
// R14 - User settings load failure sets bitfield bit 1 under FF00h.
// R15 - Secondary processor CRC error sets bitfield bit 3 under FF00h.
// R16 - Secondary processor CAN error sets bitfield bit 4 under FF00h.
// R17 - Secondary processor errors only reported in category-3 safety builds.
// R18 - Frame: code low, code high, error register, bitfield, four zeros.
// R19 - Heartbeat reports the network state periodically.
// R20 - Emergency sent on appearance or full clearing, not while persisting.
`timescale 1ns/10ps
module cef_top
   import cef_pkg::*;
#(
   parameter int AXES = 3,
   parameter int HB_PERIOD_CYC = HB_CYCLES
)(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Network management
   input wire logic [7:0] nmt_state,
   input wire logic node_reinit,
   // Filter selection access
   input wire logic filt_wr,
   input wire logic filt_wdata,
   output logic filt_wr_ack,
   output logic filt_wr_err,
   output logic filt_pending,
   output logic filt_active,
   // Receive PDO speed writes
   input wire logic [2:0] rpdo_map,
   input wire logic rpdo_wr,
   input wire logic [7:0] rpdo_sub,
   input wire logic [15:0] rpdo_data,
   // Object dictionary reads of the speed array
   input wire logic od_rd,
   input wire logic [7:0] od_sub,
   output logic od_rvalid,
   output logic od_rerr,
   output logic [15:0] od_rdata,
   // Speeds towards the inclination computation
   output logic speed_use,
   output logic [15:0] speed_x,
   output logic [15:0] speed_y,
   output logic [15:0] speed_z,
   // Error sources
   input wire logic [7:0] err_reg,
   input wire logic can_err_passive,
   input wire logic can_busoff_recovered,
   input wire logic user_load_fail,
   input wire logic sec_crc_err,
   input wire logic sec_can_err,
   input wire logic safety_cat3,
   // Emergency frame out
   output logic emcy_valid,
   input wire logic emcy_ready,
   output logic [63:0] emcy_data,
   // Heartbeat out
   output logic hb_pulse,
   output logic [7:0] hb_state
);
   generate
      if (AXES != 3) begin : g_bad_axes
         $error("cef_top serves exactly three speed axes");
      end
      if (HB_PERIOD_CYC < 2) begin : g_bad_hb
         $error("cef_top heartbeat period must be at least two cycles");
      end
   endgenerate

   // Sub-index to one-hot axis select
   function automatic logic [2:0] axis_sel(input logic [7:0] sub);
      logic [2:0] sel;
      sel = 3'b000;
      case (sub)
         SUB_X: sel = 3'b001;
         SUB_Y: sel = 3'b010;
         SUB_Z: sel = 3'b100;
         default: sel = 3'b000;
      endcase
      return sel;
   endfunction

   // Filter selection
   logic is_preop;
   logic filt_accept;
   logic filt_reject;

   assign is_preop = (nmt_state == NMT_PREOP);
   assign filt_accept = filt_wr && is_preop; // R5
   assign filt_reject = filt_wr && !is_preop; // R5

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         filt_pending <= FILT_RESET; // R7
         filt_wr_ack <= 1'b0;
         filt_wr_err <= 1'b0;
      end else begin
         if (filt_accept) begin
            filt_pending <= filt_wdata; // R5
         end
         filt_wr_ack <= filt_accept;
         filt_wr_err <= filt_reject;
      end
   end

   // Active algorithm only follows the pending value on reinit
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         filt_active <= FILT_RESET; // R7
      end else if (node_reinit) begin
         filt_active <= filt_pending; // R6
      end
   end

   // Speed inputs
   logic [2:0] wr_sel;
   logic [2:0] rd_sel;
   logic kalman_on;
   logic [15:0] speed_raw [0:2];

   assign wr_sel = rpdo_wr ? // R2 R4
      (axis_sel(rpdo_sub) & rpdo_map) : 3'b000;
   assign rd_sel = axis_sel(od_sub);
   assign kalman_on = (filt_active == FILT_KALMAN);

   genvar ax;
   generate
      for (ax = 0; ax < 3; ax++) begin : g_axis
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               speed_raw[ax] <= SPEED_RESET;
            end else if (wr_sel[ax]) begin
               speed_raw[ax] <= rpdo_data; // R4
            end
         end
      end
   endgenerate

   // Speeds seen by the computation, zero unless Kalman is active
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         speed_use <= 1'b0;
         speed_x <= SPEED_RESET;
         speed_y <= SPEED_RESET;
         speed_z <= SPEED_RESET;
      end else begin
         speed_use <= kalman_on; // R1
         speed_x <= kalman_on ? speed_raw[0] : SPEED_RESET; // R1
         speed_y <= kalman_on ? speed_raw[1] : SPEED_RESET; // R1
         speed_z <= kalman_on ? speed_raw[2] : SPEED_RESET; // R1
      end
   end

   // Object dictionary read path
   logic rd_count;
   logic rd_hit;
   logic [15:0] next_rdata;

   assign rd_count = (od_sub == SUB_COUNT);
   assign rd_hit = rd_count || (rd_sel != 3'b000);
   assign next_rdata = rd_count ? {8'h00, SPEED_AXES} : // R3
      rd_sel[0] ? speed_raw[0] :
      rd_sel[1] ? speed_raw[1] :
      rd_sel[2] ? speed_raw[2] : 16'h0000;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         od_rvalid <= 1'b0;
         od_rerr <= 1'b0;
         od_rdata <= 16'h0000;
      end else begin
         od_rvalid <= od_rd && rd_hit;
         od_rerr <= od_rd && !rd_hit;
         if (od_rd) begin
            od_rdata <= next_rdata;
         end
      end
   end

   // Error condition levels and their previous values
   logic sec_crc_q;
   logic sec_can_q;
   logic [7:0] dev_bits;
   logic [7:0] dev_bits_d;
   logic passive_d;
   logic any_now;
   logic any_d;

   assign sec_crc_q = sec_crc_err && safety_cat3; // R17
   assign sec_can_q = sec_can_err && safety_cat3; // R17

   always_comb begin
      dev_bits = MB_CLEAR;
      dev_bits[MB_USER_LOAD] = user_load_fail; // R14
      dev_bits[MB_SEC_CRC] = sec_crc_q; // R15
      dev_bits[MB_SEC_CAN] = sec_can_q; // R16
   end

   assign any_now = can_err_passive || (dev_bits != MB_CLEAR);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dev_bits_d <= MB_CLEAR;
         passive_d <= 1'b0;
         any_d <= 1'b0;
      end else begin
         dev_bits_d <= dev_bits;
         passive_d <= can_err_passive;
         any_d <= any_now;
      end
   end

   // Events: appearance of a condition, or all conditions gone
   logic ev_passive;
   logic ev_busoff;
   logic ev_dev;
   logic ev_clear;

   assign ev_passive = can_err_passive && !passive_d; // R11 R20
   assign ev_busoff = can_busoff_recovered; // R12
   assign ev_dev = ((dev_bits & ~dev_bits_d) != MB_CLEAR); // R13 R20
   assign ev_clear = any_d && !any_now; // R10 R20

   // Pending message flags, set wins over clear
   logic pend_passive;
   logic pend_busoff;
   logic pend_dev;
   logic pend_clear;
   logic tx_busy;
   logic tx_load;
   logic [15:0] tx_code;
   logic [7:0] tx_mfr;
   logic take_passive;
   logic take_busoff;
   logic take_dev;
   logic take_clear;
   logic any_pend;
   cef_state_e state;
   cef_state_e next_state;

   // Fixed priority among pending messages
   assign take_passive = pend_passive;
   assign take_busoff = pend_busoff && !pend_passive;
   assign take_dev = pend_dev && !pend_passive && !pend_busoff;
   assign take_clear = pend_clear && !pend_passive && !pend_busoff &&
      !pend_dev;
   assign any_pend = pend_passive || pend_busoff || pend_dev || pend_clear;
   assign tx_load = (state == ST_LOAD);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pend_passive <= 1'b0;
         pend_busoff <= 1'b0;
         pend_dev <= 1'b0;
         pend_clear <= 1'b0;
      end else begin
         pend_passive <= ev_passive || (pend_passive &&
            !(tx_load && take_passive));
         pend_busoff <= ev_busoff || (pend_busoff &&
            !(tx_load && take_busoff));
         pend_dev <= ev_dev || (pend_dev && !(tx_load && take_dev));
         pend_clear <= ev_clear || (pend_clear &&
            !(tx_load && take_clear));
      end
   end

   // Message content for the chosen event
   always_comb begin
      tx_code = EC_NO_ERROR; // R10
      tx_mfr = MB_CLEAR; // R10
      if (take_passive) begin
         tx_code = EC_PASSIVE; // R11
         tx_mfr[MB_PASSIVE] = 1'b1; // R11
      end else if (take_busoff) begin
         tx_code = EC_BUSOFF; // R12
         tx_mfr[MB_BUSOFF] = 1'b1; // R12
      end else if (take_dev) begin
         tx_code = EC_DEVICE; // R13
         tx_mfr = dev_bits; // R13 R14 R15 R16
      end
   end

   // Sequencer: wait for free frame holder, load, wait for hand-off
   always_comb begin
      case (state)
         ST_IDLE: next_state = (any_pend && !tx_busy) ? ST_LOAD : ST_IDLE;
         ST_LOAD: next_state = ST_WAIT;
         ST_WAIT: next_state = tx_busy ? ST_WAIT : ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   cef_emcy_tx u_emcy_tx (
      .clk(clk),
      .reset(reset),
      .load(tx_load),
      .code(tx_code),
      .err_reg(err_reg), // R9
      .mfr(tx_mfr), // R8
      .busy(tx_busy),
      .emcy_valid(emcy_valid),
      .emcy_ready(emcy_ready),
      .emcy_data(emcy_data)
   );

   // Heartbeat timer
   logic [31:0] hb_count;
   logic hb_wrap;

   assign hb_wrap = (hb_count == 32'(HB_PERIOD_CYC - 1));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hb_count <= 32'h00000000;
         hb_pulse <= 1'b0;
         hb_state <= NMT_RESET;
      end else begin
         hb_count <= hb_wrap ? 32'h00000000 : hb_count + 32'h00000001;
         hb_pulse <= hb_wrap; // R19
         hb_state <= nmt_state; // R19
      end
   end
endmodule

// ---- verilog/cef_pkg.sv ----
// Constants for the emergency message and filter configuration block
package cef_pkg;
   // Object dictionary
   localparam logic [15:0] SPEED_INDEX = 16'h5200;
   localparam logic [7:0] SPEED_AXES = 8'h03;
   localparam logic [7:0] SUB_COUNT = 8'h00;
   localparam logic [7:0] SUB_X = 8'h01;
   localparam logic [7:0] SUB_Y = 8'h02;
   localparam logic [7:0] SUB_Z = 8'h03;
   localparam logic [15:0] SPEED_RESET = 16'h0000;
   // Filter selection encoding
   localparam logic FILT_COMPL = 1'h0;
   localparam logic FILT_KALMAN = 1'h1;
   localparam logic FILT_RESET = FILT_COMPL;
   // Network state codes for pre-operational and for the heartbeat state at reset
   localparam logic [7:0] NMT_PREOP = 8'h7F;
   localparam logic [7:0] NMT_RESET = 8'h00;
   // Emergency error codes
   localparam logic [15:0] EC_NO_ERROR = 16'h0000;
   localparam logic [15:0] EC_PASSIVE = 16'h8120;
   localparam logic [15:0] EC_BUSOFF = 16'h8140;
   localparam logic [15:0] EC_DEVICE = 16'hFF00;
   // Manufacturer bitfield positions
   localparam int MB_USER_LOAD = 1;
   localparam int MB_SEC_CRC = 3;
   localparam int MB_SEC_CAN = 4;
   localparam int MB_PASSIVE = 5;
   localparam int MB_BUSOFF = 6;
   localparam logic [7:0] MB_CLEAR = 8'h00;
   // Emergency frame layout, byte positions
   localparam int FB_CODE_LO = 0;
   localparam int FB_CODE_HI = 1;
   localparam int FB_ERR_REG = 2;
   localparam int FB_MFR = 3;
   localparam logic [31:0] FB_PAD = 32'h00000000;
   // Heartbeat timing
   localparam int CLK_KHZ = 40000;
   localparam int HB_PERIOD_MS = 100;
   localparam int HB_CYCLES = HB_PERIOD_MS * CLK_KHZ;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_LOAD = 3'b010,
      ST_WAIT = 3'b100
   } cef_state_e;
endpackage

// ---- verilog/cef_emcy_tx.sv ----
// Emergency frame holder with valid/ready hand-off
`timescale 1ns/10ps
module cef_emcy_tx
   import cef_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Load side
   input wire logic load,
   input wire logic [15:0] code,
   input wire logic [7:0] err_reg,
   input wire logic [7:0] mfr,
   output logic busy,
   // Transmit side
   output logic emcy_valid,
   input wire logic emcy_ready,
   output logic [63:0] emcy_data
);
   logic [63:0] next_frame;

   // Code low, code high, error register, bitfield, four zero bytes
   assign next_frame = {FB_PAD, mfr, err_reg, // R18 R9 R8
      code[15:8], code[7:0]};

   assign busy = emcy_valid;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         emcy_valid <= 1'b0;
         emcy_data <= 64'h0000000000000000;
      end else if (load && !emcy_valid) begin
         emcy_valid <= 1'b1;
         emcy_data <= next_frame;
      end else if (emcy_valid && emcy_ready) begin
         emcy_valid <= 1'b0;
      end
   end
endmodule

// ---- test/cef_master_model.sv ----
// Far-side master that takes emergency frames after a set delay
`timescale 1ns/10ps
module cef_master_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Frame hand-off
   input wire logic emcy_valid,
   input wire logic [63:0] emcy_data,
   output logic emcy_ready,
   // Observation
   input wire logic [3:0] dly,
   output logic [63:0] last,
   output int frames
);
   logic [3:0] wait_cnt;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         emcy_ready <= 1'b0;
         wait_cnt <= 4'h0;
         frames <= 0;
         last <= 64'h0;
      end else if (emcy_valid && emcy_ready) begin
         last <= emcy_data;
         frames <= frames + 1;
         emcy_ready <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (emcy_valid) begin
         wait_cnt <= wait_cnt + 4'h1;
         emcy_ready <= (wait_cnt >= dly);
      end
   end
endmodule

// ---- test/cef_top_props.sv ----
// Concurrent checks on the emergency and filter block ports
`timescale 1ns/10ps
module cef_top_props #(
   parameter int HB = 16
)(
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] nmt_state,
   input wire logic node_reinit,
   input wire logic filt_wr,
   input wire logic filt_wr_ack,
   input wire logic filt_wr_err,
   input wire logic filt_active,
   input wire logic od_rd,
   input wire logic [7:0] od_sub,
   input wire logic od_rvalid,
   input wire logic [15:0] od_rdata,
   input wire logic speed_use,
   input wire logic [15:0] speed_x,
   input wire logic [7:0] err_reg,
   input wire logic emcy_valid,
   input wire logic emcy_ready,
   input wire logic [63:0] emcy_data,
   input wire logic hb_pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Cycles since the last heartbeat pulse
   int hb_gap;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hb_gap <= 0;
      end else begin
         hb_gap <= hb_pulse ? 1 : hb_gap + 1;
      end
   end
   pad_zero_a: assert property (emcy_valid |-> !emcy_data[63:32])
      else $error("pad bytes not zero");
   frame_hold_a: assert property (emcy_valid && !emcy_ready |=>
      emcy_valid && $stable(emcy_data)) else $error("frame dropped");
   err_byte_a: assert property ($rose(emcy_valid) && $stable(err_reg)
      |-> emcy_data[23:16] == err_reg) else $error("error byte wrong");
   clear_mfr_a: assert property (emcy_valid && !emcy_data[15:0]
      |-> !emcy_data[31:24]) else $error("clear bitfield set");
   dev_bits_a: assert property (emcy_valid &&
      emcy_data[15:0] == 16'hFF00
      |-> !(emcy_data[31:24] & 8'hE5) && emcy_data[31:24] != 8'h00)
      else $error("device bitfield wrong");
   filt_refuse_a: assert property (filt_wr && nmt_state != 8'h7F
      |=> filt_wr_err && !filt_wr_ack) else $error("write not refused");
   filt_hold_a: assert property (!node_reinit |=> $stable(filt_active))
      else $error("filter changed without reinit");
   speed_gate_a: assert property (1'b1 |=>
      speed_use == $past(filt_active) && (speed_use || !speed_x))
      else $error("speed gating wrong");
   count_read_a: assert property (od_rd && od_sub == 8'h00
      |=> od_rvalid && od_rdata == 16'h0003) else $error("axis count");
   hb_period_a: assert property (hb_pulse == (hb_gap == HB))
      else $error("heartbeat period");
endmodule
bind cef_top cef_top_props #(.HB(HB_PERIOD_CYC)) u_props (
   .clk(clk), .reset(reset), .nmt_state(nmt_state),
   .node_reinit(node_reinit), .filt_wr(filt_wr),
   .filt_wr_ack(filt_wr_ack), .filt_wr_err(filt_wr_err),
   .filt_active(filt_active), .od_rd(od_rd), .od_sub(od_sub),
   .od_rvalid(od_rvalid), .od_rdata(od_rdata), .speed_use(speed_use),
   .speed_x(speed_x), .err_reg(err_reg), .emcy_valid(emcy_valid),
   .emcy_ready(emcy_ready), .emcy_data(emcy_data), .hb_pulse(hb_pulse)
);

// ---- test/cef_top_tb.sv ----
// Self-checking bench for the emergency and filter block
`timescale 1ns/10ps
module cef_top_tb;
   import cef_pkg::*;
   localparam int HB = 16;
   logic clk, reset, node_reinit, filt_wr, filt_wdata, rpdo_wr, od_rd;
   logic [7:0] nmt_state, rpdo_sub, od_sub, err_reg, hb_state;
   logic [2:0] rpdo_map;
   logic [15:0] rpdo_data, od_rdata, speed_x, speed_y, speed_z;
   logic pas, bof, ulf, crc, cer, cat3, emcy_valid, emcy_ready, hb_pulse;
   logic filt_wr_ack, filt_wr_err, filt_pending, filt_active;
   logic od_rvalid, od_rerr, speed_use;
   logic [63:0] emcy_data, last;
   logic [3:0] dly;
   int frames, error_cnt, checks;
   cef_top #(.HB_PERIOD_CYC(HB)) DUT (.clk(clk), .reset(reset),
      .nmt_state(nmt_state), .node_reinit(node_reinit), .filt_wr(filt_wr),
      .filt_wdata(filt_wdata), .filt_wr_ack(filt_wr_ack),
      .filt_wr_err(filt_wr_err), .filt_pending(filt_pending),
      .filt_active(filt_active), .rpdo_map(rpdo_map), .rpdo_wr(rpdo_wr),
      .rpdo_sub(rpdo_sub), .rpdo_data(rpdo_data), .od_rd(od_rd),
      .od_sub(od_sub), .od_rvalid(od_rvalid), .od_rerr(od_rerr),
      .od_rdata(od_rdata), .speed_use(speed_use), .speed_x(speed_x),
      .speed_y(speed_y), .speed_z(speed_z), .err_reg(err_reg),
      .can_err_passive(pas), .can_busoff_recovered(bof),
      .user_load_fail(ulf), .sec_crc_err(crc), .sec_can_err(cer),
      .safety_cat3(cat3), .emcy_valid(emcy_valid), .emcy_ready(emcy_ready),
      .emcy_data(emcy_data), .hb_pulse(hb_pulse), .hb_state(hb_state));
   cef_master_model u_master (.clk(clk), .reset(reset),
      .emcy_valid(emcy_valid), .emcy_data(emcy_data),
      .emcy_ready(emcy_ready), .dly(dly), .last(last), .frames(frames));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input string nm, input logic [63:0] e, g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic do_reset;
      reset = 1'b1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
   endtask
   task automatic wr(input logic [7:0] s, input logic [15:0] d);
      rpdo_sub = s;
      rpdo_data = d;
      rpdo_wr = 1'b1;
      step(1);
      rpdo_wr = 1'b0;
      step(1);
   endtask
   task automatic rd(input logic [7:0] s, input logic [15:0] e,
         input logic er);
      od_sub = s;
      od_rd = 1'b1;
      step(1);
      od_rd = 1'b0;
      chk("od_rvalid", !er, od_rvalid);
      chk("od_rerr", er, od_rerr);
      if (!er)
         chk("od_rdata", e, od_rdata);
      step(1);
   endtask
   task automatic frame(input logic [15:0] c, input logic [7:0] m);
      int f0;
      f0 = frames;
      for (int i = 0; i < 40 && frames == f0; i++)
         step(1);
      chk("frame count", f0 + 1, frames);
      chk("emcy frame", {FB_PAD, m, err_reg, c}, last);
   endtask
   task automatic quiet(input int n);
      int f0;
      f0 = frames;
      step(n);
      chk("no frame", f0, frames);
   endtask
   task automatic t_speed;
      rpdo_map = 3'b101;
      wr(SUB_X, 16'h8001);
      wr(SUB_Y, 16'h1234);
      wr(SUB_Z, 16'h7FFE);
      step(3);
      chk("speed_x gated", 0, speed_x);
      rd(SUB_X, 16'h8001, 1'b0);
      rd(SUB_Y, 16'h0000, 1'b0);
      rd(SUB_Z, 16'h7FFE, 1'b0);
      rd(SUB_COUNT, 16'h0003, 1'b0);
      rd(8'h04, 16'h0000, 1'b1);
      $display("speed test done");
   endtask
   task automatic t_filter;
      nmt_state = 8'h05;
      filt_wdata = FILT_KALMAN;
      filt_wr = 1'b1;
      step(1);
      filt_wr = 1'b0;
      chk("refused", 1, filt_wr_err);
      chk("pending kept", FILT_COMPL, filt_pending);
      step(1);
      nmt_state = NMT_PREOP;
      filt_wr = 1'b1;
      step(1);
      filt_wr = 1'b0;
      chk("accepted", 1, filt_wr_ack);
      chk("pending", FILT_KALMAN, filt_pending);
      step(3);
      chk("old filter", FILT_COMPL, filt_active);
      node_reinit = 1'b1;
      step(1);
      node_reinit = 1'b0;
      step(1);
      chk("kalman", FILT_KALMAN, filt_active);
      chk("speed used", 1, speed_use);
      chk("speed_x", 16'h8001, speed_x);
      chk("speed_y", 0, speed_y);
      chk("speed_z", 16'h7FFE, speed_z);
      $display("filter test done");
   endtask
   task automatic t_emcy;
      err_reg = 8'h11;
      pas = 1'b1;
      frame(EC_PASSIVE, 8'h20);
      quiet(20);
      pas = 1'b0;
      frame(EC_NO_ERROR, MB_CLEAR);
      bof = 1'b1;
      step(1);
      bof = 1'b0;
      frame(EC_BUSOFF, 8'h40);
      dly = 4'h5;
      err_reg = 8'h05;
      ulf = 1'b1;
      frame(EC_DEVICE, 8'h02);
      cat3 = 1'b1;
      crc = 1'b1;
      frame(EC_DEVICE, 8'h0A);
      cer = 1'b1;
      frame(EC_DEVICE, 8'h1A);
      {ulf, crc, cer, cat3} = 4'h0;
      frame(EC_NO_ERROR, MB_CLEAR);
      crc = 1'b1;
      quiet(20);
      crc = 1'b0;
      $display("emergency test done");
   endtask
   task automatic t_hb;
      int n;
      n = 0;
      for (int i = 0; i < 40 && hb_pulse !== 1'b1; i++)
         step(1);
      step(1);
      while (hb_pulse !== 1'b1 && n < 40) begin
         n++;
         step(1);
      end
      chk("hb period", HB - 1, n);
      chk("hb state", nmt_state, hb_state);
      $display("heartbeat test done");
   endtask
   initial begin
      #75000;
      error_cnt++;
      give_verdict();
   end
   initial begin
      {node_reinit, filt_wr, filt_wdata, rpdo_wr, od_rd} = 5'h00;
      {pas, bof, ulf, crc, cer, cat3} = 6'h00;
      {nmt_state, rpdo_sub, od_sub, err_reg} = 32'h05000000;
      {rpdo_map, rpdo_data, dly} = 23'h0;
      do_reset();
      t_speed();
      t_filter();
      t_emcy();
      t_hb();
      do_reset();
      step(1);
      chk("filter default", FILT_RESET, filt_active);
      give_verdict();
   end
endmodule
